//--- lpm_mode_ctrl.v
// low-power mode controller with status word, apb registers and clock gates
//
// Local design decisions: the APB interface to the registers and the register offsets.
`include "lpm_map.vh"

// Contract
// RQ1: With the cpu halt bit set the cpu and internal bus stop until an interrupt or reset.
// RQ2: In levels 0 and 1 the clock generator runs; main and aux clock follow the other mode bits.
// RQ3: Setting the cpu halt bit does not stop peripherals.
// RQ4: Each peripheral runs by its own control bit and module enable, in active mode and levels 0 and 1.
// RQ5: In levels 0 and 1 ports and registers hold and any enabled interrupt wakes.
// RQ6: With cpu halt and main clock off set, cpu, main clock and bus stop (levels 2, 3).
// RQ7: In levels 2 and 3 main clock peripherals are stopped.
// RQ8: In levels 2 and 3 aux clock peripherals follow their own control and enable.
// RQ9: In levels 2 and 3 enabled interrupts from active peripherals or the reset pin wake.
// RQ10: In level 4 all activity stops and only enabled external interrupts wake.
// RQ11: Cpu halt is mask 10h; clearing it in the stacked word returns to active on restore.
// RQ12: Software decides before level 4 whether the frequency integrator is held.
// RQ13: Interrupt entry pushes status word and pc, then clears osc stop, main clock off, cpu halt.
// RQ14: Level 1 is loop control off with cpu halt, main and aux clocks still running.
// RQ15: Level 3 has both clock generator bits, stops main clock, loop and oscillator.
// RQ16: Level 4 is osc stop and cpu halt regardless of the generator bits.
// RQ17: Mode bit changes act on the next cycle and clock gating is glitch-free; here the clock enable outputs and periph_run change two cycles after the word.
module lpm_mode_ctrl #(
   parameter NPER = 8
) (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // processor core side
   input wire sw_write,
   input wire [15:0] sw_wdata,
   input wire sw_restore,
   input wire [15:0] sw_restore_data,
   input wire [15:0] pc_value,
   output reg [15:0] status_word,
   output reg cpu_run,
   output reg bus_run,
   output reg push_valid,
   output reg [15:0] push_data,
   output reg int_taken,
   // wake sources
   input wire [NPER-1:0] periph_irq,
   input wire [NPER-1:0] periph_on_aux,
   input wire [NPER-1:0] periph_external,
   input wire reset_nmi_pin,
   // clock system
   output reg main_clk_en,
   output reg aux_clk_en,
   output reg loop_ctrl_en,
   output reg digital_osc_en,
   output reg dc_gen_en,
   output reg crystal_en,
   output reg integrator_hold,
   output reg [NPER-1:0] periph_run
);

   reg [7:0] module_en;
   reg [7:0] periph_ctrl;
   reg [NPER-1:0] int_enable;
   reg loop_cfg;
   reg [1:0] is_state;
   reg [1:0] next_is_state;
   reg [2:0] next_mode;
   reg [2:0] mode;
   reg next_main;
   reg next_aux;
   reg next_loop;
   reg next_osc;
   reg next_dc;
   reg next_xtal;
   reg wake;
   reg [31:0] next_prdata;
   reg addr_ok;
   wire [NPER-1:0] aux_ok;
   wire [NPER-1:0] per_req;
   wire main_gate;
   wire aux_gate;
   wire loop_gate;
   wire osc_gate;
   wire dc_gate;
   wire xtal_gate;
   wire apb_wr;
   wire apb_rd;
   wire halt;
   wire osc_stop;
   wire clk_off;
   wire loop_off;

   assign halt = status_word[`LPM_BIT_CPU_HALT];
   assign osc_stop = status_word[`LPM_BIT_OSC_STOP];
   assign clk_off = status_word[`LPM_BIT_MAIN_CLK_OFF];
   assign loop_off = status_word[`LPM_BIT_LOOP_CTRL_OFF];
   assign apb_wr = psel && penable && pwrite && pready;
   assign apb_rd = psel && !penable && !pwrite;

   // mode decode from the four operating bits
   always @* begin
      next_mode = `LPM_MODE_ACTIVE;
      if (halt && osc_stop)
         next_mode = `LPM_MODE_SL4; // [RQ16]
      else if (halt && clk_off && loop_off)
         next_mode = `LPM_MODE_SL3; // [RQ15]
      else if (halt && clk_off)
         next_mode = `LPM_MODE_SL2; // [RQ6]
      else if (halt && loop_off)
         next_mode = `LPM_MODE_SL1; // [RQ14]
      else if (halt)
         next_mode = `LPM_MODE_SL0; // [RQ1]
   end

   // clock generator controls per level
   always @* begin
      next_main = 1'b1;
      next_aux = 1'b1;
      next_loop = 1'b1;
      next_osc = 1'b1;
      next_dc = 1'b1;
      next_xtal = 1'b1;
      case (next_mode)
         `LPM_MODE_ACTIVE, `LPM_MODE_SL0: begin
         end
         `LPM_MODE_SL1: begin
            next_loop = 1'b0; // [RQ14] [RQ2]
         end
         `LPM_MODE_SL2: begin
            next_main = 1'b0; // [RQ6]
            next_loop = 1'b0;
         end
         `LPM_MODE_SL3: begin
            next_main = 1'b0; // [RQ15]
            next_loop = 1'b0;
            next_osc = 1'b0;
            next_dc = 1'b0;
         end
         `LPM_MODE_SL4: begin
            next_main = 1'b0; // [RQ10] [RQ16]
            next_aux = 1'b0;
            next_loop = 1'b0;
            next_osc = 1'b0;
            next_dc = 1'b0;
            next_xtal = 1'b0;
         end
         default: begin
         end
      endcase
   end

   // each gate flop changes only at a rising edge: next cycle, no runts
   lpm_clock_gate u_main (.pclk(pclk), .presetn(presetn),
      .run(next_main), .enable(main_gate)); // [RQ17]
   lpm_clock_gate u_aux (.pclk(pclk), .presetn(presetn),
      .run(next_aux), .enable(aux_gate));
   lpm_clock_gate u_loop (.pclk(pclk), .presetn(presetn),
      .run(next_loop), .enable(loop_gate));
   lpm_clock_gate u_osc (.pclk(pclk), .presetn(presetn),
      .run(next_osc), .enable(osc_gate));
   lpm_clock_gate u_dc (.pclk(pclk), .presetn(presetn),
      .run(next_dc), .enable(dc_gate));
   lpm_clock_gate u_xtal (.pclk(pclk), .presetn(presetn),
      .run(next_xtal), .enable(xtal_gate));

   // peripheral run: own control and module enable, plus its clock
   genvar gi;
   generate
      for (gi = 0; gi < NPER; gi = gi + 1) begin : g_per
         assign per_req[gi] = periph_ctrl[gi % 8] && module_en[gi % 8]; // [RQ4]
         // aux peripherals ignore main clock gating [RQ8]
         assign aux_ok[gi] = periph_on_aux[gi] ? aux_gate : main_gate; // [RQ7]
      end
   endgenerate

   // wake: level 4 only external sources, 2/3 active peripherals or pin
   // decoded from the live word: the registered mode lags one cycle
   always @* begin
      case (next_mode)
         `LPM_MODE_SL4:
            wake = |(periph_irq & int_enable & periph_external); // [RQ10]
         `LPM_MODE_SL2, `LPM_MODE_SL3:
            wake = |(periph_irq & int_enable & per_req & periph_on_aux)
               || reset_nmi_pin; // [RQ9]
         default:
            wake = |(periph_irq & int_enable) || reset_nmi_pin; // [RQ5]
      endcase
   end

   // interrupt entry sequence
   always @* begin
      next_is_state = is_state;
      case (is_state)
         `LPM_IS_IDLE:
            if (wake && halt)
               next_is_state = `LPM_IS_PUSH_SW;
         `LPM_IS_PUSH_SW:
            next_is_state = `LPM_IS_PUSH_PC;
         `LPM_IS_PUSH_PC:
            next_is_state = `LPM_IS_CLEAR;
         `LPM_IS_CLEAR:
            next_is_state = `LPM_IS_IDLE;
         default:
            next_is_state = `LPM_IS_IDLE;
      endcase
   end

   always @* begin
      addr_ok = 1'b1;
      next_prdata = 32'h00000000;
      case (paddr)
         `LPM_OFF_STATUS_WORD: next_prdata = {16'h0000, status_word};
         `LPM_OFF_MODULE_EN: next_prdata = {24'h000000, module_en};
         `LPM_OFF_PERIPH_CTRL: next_prdata = {24'h000000, periph_ctrl};
         `LPM_OFF_MODE_STATE: next_prdata = {29'h00000000, mode};
         `LPM_OFF_INT_ENABLE: next_prdata = {{(32-NPER){1'b0}}, int_enable};
         `LPM_OFF_LOOP_CFG: next_prdata = {31'h00000000, loop_cfg};
         default: addr_ok = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= `LPM_RST_STATUS_WORD;
         module_en <= `LPM_RST_MODULE_EN;
         periph_ctrl <= `LPM_RST_PERIPH_CTRL;
         int_enable <= {NPER{1'b0}};
         loop_cfg <= `LPM_RST_LOOP_CFG;
         is_state <= `LPM_IS_IDLE;
         mode <= `LPM_MODE_ACTIVE;
         cpu_run <= 1'b1;
         bus_run <= 1'b1;
         push_valid <= 1'b0;
         push_data <= 16'h0000;
         int_taken <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         main_clk_en <= 1'b1;
         aux_clk_en <= 1'b1;
         loop_ctrl_en <= 1'b1;
         digital_osc_en <= 1'b1;
         dc_gen_en <= 1'b1;
         crystal_en <= 1'b1;
         integrator_hold <= 1'b0;
         periph_run <= {NPER{1'b0}};
      end else begin
         is_state <= next_is_state;
         mode <= next_mode;
         // halted cpu and bus restart once the halt bit clears: entry sequence, restore or a word write
         cpu_run <= !halt; // [RQ1] [RQ5]
         bus_run <= !halt; // [RQ6]
         main_clk_en <= main_gate;
         aux_clk_en <= aux_gate;
         loop_ctrl_en <= loop_gate;
         digital_osc_en <= osc_gate;
         dc_gen_en <= dc_gate;
         crystal_en <= xtal_gate;
         // software choice, honoured while the loop is off
         integrator_hold <= loop_cfg && !next_loop; // [RQ12]
         // halt bit alone never stops a peripheral [RQ3]
         periph_run <= per_req & aux_ok;
         push_valid <= 1'b0;
         int_taken <= 1'b0;
         // apb: no wait states, read data set up during setup phase
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !addr_ok;
         if (apb_rd)
            prdata <= next_prdata;
         // status word updates: entry clear, restore, core write, apb write
         if (is_state == `LPM_IS_PUSH_SW) begin
            push_valid <= 1'b1; // [RQ13]
            push_data <= status_word;
         end else if (is_state == `LPM_IS_PUSH_PC) begin
            push_valid <= 1'b1;
            push_data <= pc_value;
         end else if (is_state == `LPM_IS_CLEAR) begin
            status_word[`LPM_BIT_OSC_STOP] <= 1'b0; // [RQ13]
            status_word[`LPM_BIT_MAIN_CLK_OFF] <= 1'b0;
            status_word[`LPM_BIT_CPU_HALT] <= 1'b0;
            int_taken <= 1'b1;
         end else if (sw_restore) begin
            // restored word may have halt cleared: back to active [RQ11]
            status_word <= sw_restore_data;
         end else if (sw_write) begin
            status_word <= sw_wdata; // [RQ17]
         end else if (apb_wr && paddr == `LPM_OFF_STATUS_WORD) begin
            status_word <= pwdata[15:0];
         end
         if (apb_wr && !pslverr) begin
            case (paddr)
               `LPM_OFF_MODULE_EN: module_en <= pwdata[7:0];
               `LPM_OFF_PERIPH_CTRL: periph_ctrl <= pwdata[7:0];
               `LPM_OFF_INT_ENABLE: int_enable <= pwdata[NPER-1:0];
               `LPM_OFF_LOOP_CFG: loop_cfg <= pwdata[0];
               default: begin
               end
            endcase
         end
      end
   end

endmodule // lpm_mode_ctrl

//--- lpm_map.vh
// register map, bit positions and mode codes of the low-power mode controller
`ifndef LPM_MAP_VH
`define LPM_MAP_VH

// apb word offsets (byte addresses)
`define LPM_OFF_STATUS_WORD 12'h000
`define LPM_OFF_MODULE_EN 12'h004
`define LPM_OFF_PERIPH_CTRL 12'h008
`define LPM_OFF_MODE_STATE 12'h00C
`define LPM_OFF_INT_ENABLE 12'h010
`define LPM_OFF_LOOP_CFG 12'h014

// status word bit positions (cpu_halt_bit mask 10h)
`define LPM_BIT_CPU_HALT 4
`define LPM_BIT_OSC_STOP 5
`define LPM_BIT_LOOP_CTRL_OFF 6
`define LPM_BIT_MAIN_CLK_OFF 7
`define LPM_MODE_MASK 16'h00F0

// reset values
`define LPM_RST_STATUS_WORD 16'h0000
`define LPM_RST_MODULE_EN 8'h00
`define LPM_RST_PERIPH_CTRL 8'h00
`define LPM_RST_INT_ENABLE 8'h00
`define LPM_RST_LOOP_CFG 1'b0

// operating mode codes
`define LPM_MODE_ACTIVE 3'h0
`define LPM_MODE_SL0 3'h1
`define LPM_MODE_SL1 3'h2
`define LPM_MODE_SL2 3'h3
`define LPM_MODE_SL3 3'h4
`define LPM_MODE_SL4 3'h5

// interrupt entry sequence states
`define LPM_IS_IDLE 2'h0
`define LPM_IS_PUSH_SW 2'h1
`define LPM_IS_PUSH_PC 2'h2
`define LPM_IS_CLEAR 2'h3

`endif

//--- lpm_clock_gate.v
// glitch-free clock enable gate, a flop registered on the rising edge
module lpm_clock_gate (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // control
   input wire run,
   // gated enable
   output reg enable
);

   // the enable only changes at a rising edge, so a downstream gate
   // combining it with the clock never sees a runt pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= 1'b1;
      end else begin
         enable <= run;
      end
   end

endmodule // lpm_clock_gate

//--- lpm_mode_ctrl_monitor.sv
// assertion checker for the low-power mode controller ports
module lpm_mon #(
   parameter NPER = 8
) (
   input wire pclk,
   input wire presetn,
   input wire [15:0] status_word,
   input wire cpu_run,
   input wire bus_run,
   input wire push_valid,
   input wire [15:0] push_data,
   input wire int_taken,
   input wire sw_restore,
   input wire [15:0] sw_restore_data,
   input wire [NPER-1:0] periph_run,
   input wire [NPER-1:0] periph_on_aux,
   input wire main_clk_en,
   input wire aux_clk_en,
   input wire loop_ctrl_en,
   input wire digital_osc_en,
   input wire dc_gen_en,
   input wire crystal_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_halt;
      $rose(status_word[4]) |-> ##[1:3] (!cpu_run && !bus_run);
   endproperty
   a_halt: assert property (p_halt) else $error("cpu not halted");
   property p_sl0;
      (status_word[7:4] == 4'h1) [*4] |-> main_clk_en && aux_clk_en
         && loop_ctrl_en;
   endproperty
   a_sl0: assert property (p_sl0) else $error("level 0 clocks");
   property p_sl1;
      (status_word[7:4] == 4'h5) [*4] |-> !loop_ctrl_en && main_clk_en
         && aux_clk_en;
   endproperty
   a_sl1: assert property (p_sl1) else $error("level 1 clocks");
   property p_sl2;
      (status_word[7:4] == 4'h9) [*4] |-> !main_clk_en && aux_clk_en
         && dc_gen_en && (periph_run & ~periph_on_aux) == '0;
   endproperty
   a_sl2: assert property (p_sl2) else $error("level 2 clocks");
   property p_sl3;
      (status_word[7:4] == 4'hD) [*4] |-> !main_clk_en && !loop_ctrl_en
         && !digital_osc_en && !dc_gen_en && aux_clk_en;
   endproperty
   a_sl3: assert property (p_sl3) else $error("level 3 clocks");
   property p_sl4;
      (status_word[5:4] == 2'b11) [*4] |-> !aux_clk_en && !main_clk_en
         && !digital_osc_en && !crystal_en && periph_run == '0;
   endproperty
   a_sl4: assert property (p_sl4) else $error("level 4 clocks");
   property p_push;
      $rose(push_valid) |-> push_data == status_word ##1 push_valid
         ##1 int_taken;
   endproperty
   a_push: assert property (p_push) else $error("entry push order");
   property p_clear;
      int_taken |-> ##[0:1] (status_word & 16'h00B0) == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("mode bits kept");
   property p_restore;
      sw_restore && !push_valid |=> status_word == $past(sw_restore_data);
   endproperty
   a_restore: assert property (p_restore) else $error("restore lost");
endmodule // lpm_mon

bind lpm_mode_ctrl lpm_mon #(.NPER(NPER)) i_lpm_mon (.pclk(pclk),
   .presetn(presetn), .status_word(status_word), .cpu_run(cpu_run),
   .bus_run(bus_run), .push_valid(push_valid), .push_data(push_data),
   .int_taken(int_taken), .sw_restore(sw_restore),
   .sw_restore_data(sw_restore_data), .periph_run(periph_run),
   .periph_on_aux(periph_on_aux), .main_clk_en(main_clk_en),
   .aux_clk_en(aux_clk_en), .loop_ctrl_en(loop_ctrl_en),
   .digital_osc_en(digital_osc_en), .dc_gen_en(dc_gen_en),
   .crystal_en(crystal_en));

//--- lpm_core_model.sv
// processor core model: writes the status word, returns from interrupts
module lpm_core_model (
   input wire pclk,
   input wire push_valid,
   input wire [15:0] push_data,
   input wire int_taken,
   input wire [15:0] clr_mask,
   output reg sw_write,
   output reg [15:0] sw_wdata,
   output reg sw_restore,
   output reg [15:0] sw_restore_data,
   output reg [15:0] pc_value
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [15:0] stacked;
   reg got;
   reg [2:0] isr_cnt;
   initial begin
      {sw_write, sw_restore, got, isr_cnt} = 6'h00;
      sw_wdata = 16'h0000;
      sw_restore_data = 16'hFFFF;
      pc_value = 16'hC0DE;
   end
   // the service routine takes a few cycles, so a level wake source is gone
   always @(posedge pclk) begin
      sw_restore <= 1'b0;
      if (push_valid && !got) begin
         stacked <= push_data;
         got <= 1'b1;
      end
      if (int_taken)
         isr_cnt <= 3'h4;
      else if (isr_cnt != 3'h0)
         isr_cnt <= isr_cnt - 3'h1;
      if (isr_cnt == 3'h1) begin
         sw_restore <= 1'b1;
         sw_restore_data <= stacked & ~clr_mask;
         got <= 1'b0;
      end
   end
   task set_word(input [15:0] w);
      begin
         @(posedge pclk);
         sw_write <= 1'b1;
         sw_wdata <= w;
         @(posedge pclk);
         sw_write <= 1'b0;
         sw_wdata <= ~w;
      end
   endtask
endmodule // lpm_core_model

//--- tb_top.sv
// self-checking bench for the low-power mode controller
`include "lpm_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [95:0] LW = 96'h0010_0050_0090_00D0_0030_00F0;
   localparam [95:0] LEXP = 96'h0103_0203_0301_0401_0500_0500;
   reg pclk, presetn, psel, penable, pwrite, reset_nmi_pin, err_seen;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd;
   reg [7:0] periph_irq, periph_on_aux, periph_external;
   reg [15:0] clr_mask;
   wire [31:0] prdata;
   wire pready, pslverr, sw_write, sw_restore, cpu_run, bus_run;
   wire push_valid, int_taken, main_clk_en, aux_clk_en, loop_ctrl_en;
   wire digital_osc_en, dc_gen_en, crystal_en, integrator_hold;
   wire [15:0] sw_wdata, sw_restore_data, pc_value, status_word, push_data;
   wire [7:0] periph_run;
   integer num_errors, cmp_count, i;
   reg [15:0] pq [$];
   lpm_mode_ctrl #(.NPER(8)) i_lpm_mode_ctrl (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sw_write(sw_write), .sw_wdata(sw_wdata),
      .sw_restore(sw_restore), .sw_restore_data(sw_restore_data),
      .pc_value(pc_value), .status_word(status_word), .cpu_run(cpu_run),
      .bus_run(bus_run), .push_valid(push_valid), .push_data(push_data),
      .int_taken(int_taken), .periph_irq(periph_irq),
      .periph_on_aux(periph_on_aux), .periph_external(periph_external),
      .reset_nmi_pin(reset_nmi_pin), .main_clk_en(main_clk_en),
      .aux_clk_en(aux_clk_en), .loop_ctrl_en(loop_ctrl_en),
      .digital_osc_en(digital_osc_en), .dc_gen_en(dc_gen_en),
      .crystal_en(crystal_en), .integrator_hold(integrator_hold),
      .periph_run(periph_run));
   lpm_core_model i_lpm_core_model (.pclk(pclk), .push_valid(push_valid),
      .push_data(push_data), .int_taken(int_taken), .clr_mask(clr_mask),
      .sw_write(sw_write), .sw_wdata(sw_wdata), .sw_restore(sw_restore),
      .sw_restore_data(sw_restore_data), .pc_value(pc_value));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (push_valid === 1'b1)
         pq.push_back(push_data);
   end
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 20);
         rd = prdata;
         err_seen = pslverr;
         {psel, penable} <= 2'b00;
         if (n >= 20)
            chk("pready", 0, 1);
      end
   endtask
   task wake(input [7:0] irq, input nmi, input exp);
      integer n;
      reg got;
      begin
         {periph_irq, reset_nmi_pin} <= {irq, nmi};
         got = 1'b0;
         for (n = 0; n < 20 && !got; n = n + 1) begin
            @(posedge pclk);
            got = (int_taken === 1'b1);
         end
         {periph_irq, reset_nmi_pin} <= 9'h000;
         chk("int taken", got, exp);
         repeat (10) @(posedge pclk);
      end
   endtask
   task t_reset;
      begin
         apb(0, `LPM_OFF_STATUS_WORD, 0);
         chk("status word", rd, 0);
         chk("clock enables", {main_clk_en, aux_clk_en, loop_ctrl_en,
            digital_osc_en, dc_gen_en, crystal_en, cpu_run}, 7'h7F);
         apb(0, 12'h018, 0);
         chk("unmapped error", err_seen, 32'h1);
         chk("unmapped data", rd, 32'h0);
         $display("t_reset done");
      end
   endtask
   task t_levels;
      begin
         apb(1, `LPM_OFF_LOOP_CFG, 32'h1);
         apb(1, `LPM_OFF_MODULE_EN, 32'h0F);
         apb(1, `LPM_OFF_PERIPH_CTRL, 32'h33);
         // the control write lands at the access edge, run follows a cycle on
         repeat (2) @(posedge pclk);
         chk("active run", periph_run, 8'h03);
         for (i = 0; i < 6; i = i + 1) begin
            i_lpm_core_model.set_word(LW[80-16*i +: 16]);
            repeat (3) @(posedge pclk);
            apb(0, `LPM_OFF_MODE_STATE, 0);
            chk("mode", rd, LEXP[88-16*i +: 8]);
            chk("periph run", periph_run, LEXP[80-16*i +: 8]);
            chk("cpu run", {cpu_run, bus_run}, 2'b00);
            chk("integrator hold", integrator_hold, i != 0);
         end
         i_lpm_core_model.set_word(16'h0000);
         $display("t_levels done");
      end
   endtask
   task t_wake;
      begin
         apb(1, `LPM_OFF_INT_ENABLE, 32'h03);
         pq.delete();
         i_lpm_core_model.set_word(16'h0090);
         wake(8'h01, 1'b0, 1'b1);
         chk("pushed status", pq[0], 16'h0090);
         chk("pushed pc", pq[1], 16'hC0DE);
         chk("restored", status_word, 16'h0090);
         clr_mask <= 16'h00F0;
         wake(8'h01, 1'b0, 1'b1);
         chk("active again", {status_word, cpu_run}, 17'h00001);
         i_lpm_core_model.set_word(16'h0090);
         wake(8'h00, 1'b1, 1'b1);
         i_lpm_core_model.set_word(16'h0030);
         wake(8'h02, 1'b0, 1'b0);
         wake(8'h01, 1'b0, 1'b1);
         chk("woke from 4", cpu_run, 1'b1);
         $display("t_wake done");
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #20000;
      num_errors = num_errors + 1;
      finish_test;
   end
   initial begin
      {num_errors, cmp_count} = 64'h0;
      {presetn, psel, penable, pwrite, reset_nmi_pin} = 5'h00;
      {paddr, pwdata} = 44'h0;
      {periph_irq, periph_on_aux, periph_external} = 24'h000101;
      clr_mask = 16'h0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_levels;
      t_wake;
      finish_test;
   end
endmodule // tb_top
